// ===== rtl/ifd_cfg.svh
`ifndef IFD_CFG_SVH
`define IFD_CFG_SVH
// ===============================================
// field positions of the 16-bit instruction word
`define IFD_INSN_W      16
`define IFD_N_HI        11
`define IFD_N_LO        8
`define IFD_M_HI        7
`define IFD_M_LO        4
`define IFD_D4_HI       3
`define IFD_D12_HI      11
`define IFD_B8_HI       7
`define IFD_IDX_ZERO    4'h0
`endif

// ===== rtl/ifd_pkg.sv
package ifd_pkg;
   // ===============================================
   // operand format classes
   typedef enum logic [3:0] {
      IFD_FMT_ZERO = 4'h0,
      IFD_FMT_N    = 4'h1,
      IFD_FMT_M    = 4'h2,
      IFD_FMT_NM   = 4'h3,
      IFD_FMT_MD   = 4'h4,
      IFD_FMT_ND4  = 4'h5,
      IFD_FMT_NMD  = 4'h6,
      IFD_FMT_D    = 4'h7,
      IFD_FMT_D12  = 4'h8,
      IFD_FMT_ND8  = 4'h9,
      IFD_FMT_I    = 4'ha,
      IFD_FMT_NI   = 4'hb
   } ifd_fmt_t;

   // extension applied to displacement or immediate
   typedef enum logic [2:0] {
      IFD_EXT_NONE  = 3'h0,
      IFD_EXT_ZX1   = 3'h1,
      IFD_EXT_ZX2   = 3'h2,
      IFD_EXT_ZX4   = 3'h3,
      IFD_EXT_SX2   = 3'h4,
      IFD_EXT_SXIMM = 3'h5,
      IFD_EXT_ZXIMM = 3'h6,
      IFD_EXT_TRAP  = 3'h7
   } ifd_ext_t;

   // format hint from the opcode classifier
   typedef struct packed {
      ifd_fmt_t fmt;
      ifd_ext_t ext;
      logic     r0_dst;
      logic     r0_src;
      logic     gbr_base;
      logic     pc_rel;
      logic     mac_pair;
      logic     n_predec;
      logic     m_postinc;
   } ifd_class_t;

   // decoded operand bundle to the datapath
   typedef struct packed {
      ifd_fmt_t    fmt;
      logic        dst_vld;
      logic [3:0]  dst_idx;
      logic        src_vld;
      logic [3:0]  src_idx;
      logic [11:0] disp_raw;
      logic [7:0]  imm_raw;
      logic [31:0] operand_ext;
      logic        r0_dst;
      logic        r0_src;
      logic        gbr_base;
      logic        pc_rel;
      logic        mac_pair;
      logic        n_predec;
      logic        m_postinc;
   } ifd_dec_t;
endpackage

// ===== rtl/ifd_classify.sv
`timescale 1ns/1ps
`include "ifd_cfg.svh"
// ===============================================
// opcode classifier: picks the operand format
module ifd_classify
   import ifd_pkg::*;
(
   // instruction in
   input  wire logic [15:0]         insn,
   // format out
   output ifd_pkg::ifd_class_t      cls
);
   logic [3:0] op_hi;
   logic [3:0] op_lo;
   logic [7:0] op_mid;

   // opcode groups by top nibble
   always_comb begin
      op_hi  = insn[15:12];
      op_lo  = insn[3:0];
      op_mid = insn[7:0];
      cls    = '0;
      cls.fmt = IFD_FMT_ZERO;
      cls.ext = IFD_EXT_NONE;
      case (op_hi)
         4'h0: begin
            if (op_lo == 4'hf) begin
               cls.fmt = IFD_FMT_NM; // mac long
               cls.mac_pair = 1'b1;
               cls.m_postinc = 1'b1;
            end else if (op_lo == 4'h2 || op_lo == 4'h3 || op_lo == 4'ha) begin
               cls.fmt = (op_lo == 4'h3) ? IFD_FMT_M : IFD_FMT_N;
               cls.pc_rel = (op_lo == 4'h3) && insn[5];
            end else if (op_lo[3:2] == 2'b01 || op_lo[3:2] == 2'b11) begin
               cls.fmt = IFD_FMT_NM;
            end else if (op_lo == 4'h9 || op_lo == 4'hb || op_lo == 4'h8) begin
               cls.fmt = (op_lo == 4'h9 && insn[5]) ? IFD_FMT_N : IFD_FMT_ZERO;
            end else begin
               cls.fmt = IFD_FMT_ZERO;
            end
         end
         4'h1: begin
            cls.fmt = IFD_FMT_NMD;
            cls.ext = IFD_EXT_ZX4;
         end
         4'h4: begin
            if (op_lo == 4'hf) begin
               cls.fmt = IFD_FMT_NM; // word multiply-accumulate
               cls.mac_pair = 1'b1;
               cls.m_postinc = 1'b1;
            end else if (op_lo == 4'hc || op_lo == 4'hd) begin
               cls.fmt = IFD_FMT_NM;
            end else if (op_lo == 4'h3 || op_lo == 4'h2) begin
               cls.fmt = IFD_FMT_N;
               cls.n_predec = 1'b1;
            end else if (op_lo == 4'h7 || op_lo == 4'h6 || op_lo == 4'he || op_lo == 4'ha) begin
               cls.fmt = IFD_FMT_M;
               cls.m_postinc = op_lo[0];
            end else if (op_lo == 4'hb) begin
               cls.fmt = IFD_FMT_M;
            end else begin
               cls.fmt = IFD_FMT_N;
            end
         end
         4'h5: begin
            cls.fmt = IFD_FMT_NMD;
            cls.ext = IFD_EXT_ZX4;
         end
         4'h2, 4'h3, 4'h6: cls.fmt = IFD_FMT_NM;
         4'h7: begin
            cls.fmt = IFD_FMT_NI;
            cls.ext = IFD_EXT_SXIMM;
         end
         4'h8: begin
            case (insn[11:8])
               4'h0, 4'h1: begin
                  cls.fmt = IFD_FMT_ND4;
                  cls.r0_src = 1'b1;
                  cls.ext = insn[8] ? IFD_EXT_ZX2 : IFD_EXT_ZX1;
               end
               4'h4, 4'h5: begin
                  cls.fmt = IFD_FMT_MD;
                  cls.r0_dst = 1'b1;
                  cls.ext = insn[8] ? IFD_EXT_ZX2 : IFD_EXT_ZX1;
               end
               4'h8: begin
                  cls.fmt = IFD_FMT_I;
                  cls.r0_src = 1'b1;
                  cls.ext = IFD_EXT_SXIMM;
               end
               default: begin
                  cls.fmt = IFD_FMT_D;
                  cls.pc_rel = 1'b1;
                  cls.ext = IFD_EXT_SX2;
               end
            endcase
         end
         4'h9, 4'hd: begin
            cls.fmt = IFD_FMT_ND8;
            cls.pc_rel = 1'b1;
            cls.ext = (op_hi == 4'h9) ? IFD_EXT_ZX2 : IFD_EXT_ZX4;
         end
         4'ha, 4'hb: begin
            cls.fmt = IFD_FMT_D12;
            cls.pc_rel = 1'b1;
            cls.ext = IFD_EXT_SX2;
         end
         4'hc: begin
            case (insn[11:8])
               4'h3: begin
                  cls.fmt = IFD_FMT_I;
                  cls.ext = IFD_EXT_TRAP; // software trap op
               end
               4'h7: begin
                  cls.fmt = IFD_FMT_D;
                  cls.pc_rel = 1'b1;
                  cls.r0_dst = 1'b1;
                  cls.ext = IFD_EXT_ZX4;
               end
               4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: begin
                  cls.fmt = IFD_FMT_I;
                  cls.ext = IFD_EXT_ZXIMM;
                  cls.gbr_base = insn[10];
                  cls.r0_src = 1'b1;
                  cls.r0_dst = (insn[9:8] != 2'b00) && !insn[10];
               end
               default: begin
                  cls.fmt = IFD_FMT_D;
                  cls.gbr_base = 1'b1;
                  cls.r0_dst = insn[10];
                  cls.r0_src = !insn[10];
                  cls.ext = (insn[9:8] == 2'b00) ? IFD_EXT_ZX1 :
                            (insn[9:8] == 2'b01) ? IFD_EXT_ZX2 : IFD_EXT_ZX4;
               end
            endcase
         end
         4'he: begin
            cls.fmt = IFD_FMT_NI;
            cls.ext = IFD_EXT_SXIMM;
         end
         default: cls.fmt = IFD_FMT_ZERO;
      endcase
      if (op_mid == 8'h00 && op_hi == 4'h0) begin
         cls = '0;
      end
   end
endmodule // ifd_classify

// ===== rtl/ifd_decoder.sv
`timescale 1ns/1ps
`include "ifd_cfg.svh"
// What this block does
// - instruction is a 16-bit word; zero format extracts no operand fields
// - opcode bits decide what each operand field means
// - destination-only: bits 11..8 destination, direct or pre-decremented pointer
// - source-only: bits 11..8 source, direct or post-incremented pointer
// - source-only register may be jump target or program-counter offset
// - base-displacement load: base 7..4, disp 3..0, into index-zero register
// - base-displacement store: base 7..4, disp 3..0, from index-zero register
// - three-field: registers 11..8 and 7..4, displacement 3..0
// - 8-bit displacement in bits 7..0 for base, pc-relative and branches
// - long branch: 12-bit displacement in bits 11..0, pc relative
// - register plus 8-bit displacement, pc-relative load into destination
// - immediate-only: 8-bit immediate in bits 7..0, incl. trap number
// - register plus immediate: register 11..8, immediate 7..0
// - 4-bit displacement zero-extended, scaled by one, two or four
// - 8 and 12-bit branch displacements sign-extended and doubled
// - immediate sign- or zero-extended by op; trap zero-extended times four
module ifd_decoder
   import ifd_pkg::*;
#(
   parameter int INSN_W = `IFD_INSN_W
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               srst,
   // fetch side
   input  wire logic [15:0]        insn,
   input  wire logic               insn_vld,
   // datapath side
   output ifd_pkg::ifd_dec_t       dec,
   output logic                    dec_vld
);
   // widths other than 16 bits are refused at elaboration
   if (INSN_W != 16) begin : g_bad_width
      $error("ifd_decoder serves 16-bit words only");
   end

   ifd_class_t cls;
   ifd_dec_t   dec_r;
   ifd_dec_t   dec_nxt;
   logic       vld_r;
   logic       vld_nxt;

   // ===============================================
   // extension and scaling
   function automatic logic [31:0] ifd_extend(input ifd_ext_t e, input logic [11:0] f);
      logic [31:0] v;
      v = 32'h0;
      case (e)
         IFD_EXT_ZX1:   v = {28'h0, f[3:0]};
         IFD_EXT_ZX2:   v = {27'h0, f[3:0], 1'b0};
         IFD_EXT_ZX4:   v = {26'h0, f[3:0], 2'b00};
         IFD_EXT_SX2:   v = {{19{f[11]}}, f, 1'b0};
         IFD_EXT_SXIMM: v = {{24{f[7]}}, f[7:0]};
         IFD_EXT_ZXIMM: v = {24'h0, f[7:0]};
         IFD_EXT_TRAP:  v = {22'h0, f[7:0], 2'b00};
         default:       v = 32'h0;
      endcase
      return v;
   endfunction

   // ===============================================
   // opcode classifier
   ifd_classify u_cls (
      .insn (insn),
      .cls  (cls)
   );

   // ===============================================
   // field extraction
   always_comb begin
      logic [11:0] fld;
      logic [7:0]  ext8;
      fld     = 12'h0;
      ext8    = 8'h0;
      dec_nxt = '0;
      vld_nxt = insn_vld && !srst;
      dec_nxt.fmt       = cls.fmt;
      dec_nxt.r0_dst    = cls.r0_dst;
      dec_nxt.r0_src    = cls.r0_src;
      dec_nxt.gbr_base  = cls.gbr_base;
      dec_nxt.pc_rel    = cls.pc_rel;
      dec_nxt.mac_pair  = cls.mac_pair;
      dec_nxt.n_predec  = cls.n_predec;
      dec_nxt.m_postinc = cls.m_postinc;
      case (cls.fmt)
         IFD_FMT_ZERO: fld = 12'h0;
         IFD_FMT_N: begin
            dec_nxt.dst_vld = 1'b1;
            dec_nxt.dst_idx = insn[`IFD_N_HI:`IFD_N_LO];
         end
         IFD_FMT_M: begin
            dec_nxt.src_vld = 1'b1;
            dec_nxt.src_idx = insn[`IFD_N_HI:`IFD_N_LO];
         end
         IFD_FMT_NM: begin
            dec_nxt.dst_vld = !cls.mac_pair;
            dec_nxt.dst_idx = insn[`IFD_N_HI:`IFD_N_LO];
            dec_nxt.src_vld = 1'b1;
            dec_nxt.src_idx = insn[`IFD_M_HI:`IFD_M_LO];
         end
         IFD_FMT_MD: begin
            dec_nxt.src_vld = 1'b1;
            dec_nxt.src_idx = insn[`IFD_M_HI:`IFD_M_LO];
            dec_nxt.dst_vld = 1'b1;
            dec_nxt.dst_idx = `IFD_IDX_ZERO;
            fld = {8'h0, insn[`IFD_D4_HI:0]};
         end
         IFD_FMT_ND4: begin
            dec_nxt.dst_vld = 1'b1;
            dec_nxt.dst_idx = insn[`IFD_M_HI:`IFD_M_LO];
            dec_nxt.src_vld = 1'b1;
            dec_nxt.src_idx = `IFD_IDX_ZERO;
            fld = {8'h0, insn[`IFD_D4_HI:0]};
         end
         IFD_FMT_NMD: begin
            dec_nxt.dst_vld = 1'b1;
            dec_nxt.dst_idx = insn[`IFD_N_HI:`IFD_N_LO];
            dec_nxt.src_vld = 1'b1;
            dec_nxt.src_idx = insn[`IFD_M_HI:`IFD_M_LO];
            fld = {8'h0, insn[`IFD_D4_HI:0]};
         end
         IFD_FMT_D: begin
            fld = {4'h0, insn[`IFD_B8_HI:0]};
            dec_nxt.dst_vld = cls.r0_dst;
            dec_nxt.src_vld = cls.r0_src;
            if (cls.ext == IFD_EXT_SX2) begin
               fld = {{4{insn[7]}}, insn[`IFD_B8_HI:0]};
            end
         end
         IFD_FMT_D12: fld = insn[`IFD_D12_HI:0];
         IFD_FMT_ND8: begin
            dec_nxt.dst_vld = 1'b1;
            dec_nxt.dst_idx = insn[`IFD_N_HI:`IFD_N_LO];
            fld = {4'h0, insn[`IFD_B8_HI:0]};
         end
         IFD_FMT_I: begin
            ext8 = insn[`IFD_B8_HI:0];
            dec_nxt.dst_vld = cls.r0_dst;
            dec_nxt.src_vld = cls.r0_src;
         end
         IFD_FMT_NI: begin
            dec_nxt.dst_vld = 1'b1;
            dec_nxt.dst_idx = insn[`IFD_N_HI:`IFD_N_LO];
            ext8 = insn[`IFD_B8_HI:0];
         end
         default: fld = 12'h0;
      endcase
      dec_nxt.disp_raw = fld;
      dec_nxt.imm_raw  = ext8;
      if (cls.fmt == IFD_FMT_ZERO) begin
         dec_nxt.operand_ext = 32'h0;
      end else if (cls.fmt == IFD_FMT_I || cls.fmt == IFD_FMT_NI) begin
         dec_nxt.operand_ext = ifd_extend(cls.ext, {4'h0, ext8});
      end else begin
         dec_nxt.operand_ext = ifd_extend(cls.ext, fld);
      end
      if (srst) begin
         dec_nxt = '0;
      end
   end

   // ===============================================
   // output register: result one clock after accept
   always_ff @(posedge clk) begin
      dec_r <= dec_nxt;
      vld_r <= vld_nxt;
   end

   assign dec     = dec_r;
   assign dec_vld = vld_r;

   // ===============================================
   // checks
   property p_vld_follow;
      @(posedge clk) disable iff (srst) insn_vld |=> dec_vld;
   endproperty
   a_vld_follow: assert property (p_vld_follow) else $error("valid lost");

   property p_ni_fields;
      @(posedge clk) disable iff (srst)
         (insn[15:12] == 4'h7) |=> (dec.dst_idx == $past(insn[11:8]))
            && (dec.imm_raw == $past(insn[7:0]));
   endproperty
   a_ni_fields: assert property (p_ni_fields) else $error("ni fields wrong");

   property p_d12;
      @(posedge clk) disable iff (srst)
         (insn[15:13] == 3'b101) |=> dec.disp_raw == $past(insn[11:0])
            && dec.operand_ext[12:1] == $past(insn[11:0]);
   endproperty
   a_d12: assert property (p_d12) else $error("long branch disp wrong");

   property p_md_r0;
      @(posedge clk) disable iff (srst)
         (dec.fmt == IFD_FMT_MD) |-> dec.dst_idx == 4'h0 && dec.disp_raw[11:4] == 8'h0;
   endproperty
   a_md_r0: assert property (p_md_r0) else $error("load not to index zero");

   property p_nd4_r0;
      @(posedge clk) disable iff (srst)
         (dec.fmt == IFD_FMT_ND4) |-> dec.src_idx == 4'h0;
   endproperty
   a_nd4_r0: assert property (p_nd4_r0) else $error("store not from index zero");

   property p_nmd;
      @(posedge clk) disable iff (srst)
         (insn[15:12] == 4'h1) |=> dec.src_idx == $past(insn[7:4])
            && dec.operand_ext == {26'h0, $past(insn[3:0]), 2'b00};
   endproperty
   a_nmd: assert property (p_nmd) else $error("nmd fields wrong");

   property p_trap;
      @(posedge clk) disable iff (srst)
         (insn[15:8] == 8'hc3) |=> dec.operand_ext == {22'h0, $past(insn[7:0]), 2'b00};
   endproperty
   a_trap: assert property (p_trap) else $error("trap scaling wrong");

   property p_zero;
      @(posedge clk) disable iff (srst)
         (dec.fmt == IFD_FMT_ZERO) |-> !dec.dst_vld && !dec.src_vld;
   endproperty
   a_zero: assert property (p_zero) else $error("zero format has operands");
endmodule // ifd_decoder

// ===== sim/ifd_fetch_model.sv
`timescale 1ns/1ps
// ===============================================
// fetch stage stand-in: hands words to the decoder
module ifd_fetch_model (
   // clock
   input  wire logic        clk,
   // pacing from bench
   input  wire logic        stall_en,
   // decoder side
   output logic [15:0]      insn,
   output logic             insn_vld
);
   logic [15:0] q[$];

   // only whole 16-bit words are queued
   function automatic void push(input logic [15:0] w);
      q.push_back(w);
   endfunction

   function automatic int depth();
      return q.size();
   endfunction

   initial begin
      insn     = 16'h0000;
      insn_vld = 1'b0;
   end

   // launch on the falling edge; idle cycles flip the bus, so the last word shows again only on every second idle cycle
   always @(negedge clk) begin
      if (q.size() != 0 && !(stall_en && $urandom_range(2) == 0)) begin
         insn     <= q.pop_front();
         insn_vld <= 1'b1;
      end else begin
         insn     <= ~insn;
         insn_vld <= 1'b0;
      end
   end
endmodule // ifd_fetch_model

// ===== sim/test_instr_format_field_decoder.sv
`timescale 1ns/1ps
// ===============================================
// bench: reference model of the operand fields
module test_instr_format_field_decoder;
   import ifd_pkg::*;
   localparam int NK      = 20;
   localparam int CYC_MAX = 5000;
   // one representative opcode per operand use, random fields under the mask
   localparam logic [15:0] TMPL [NK] = '{16'h0009, 16'h0029, 16'h4023, 16'h400e, 16'h4007,
      16'h402b, 16'h0023, 16'h300c, 16'h400f, 16'h8400, 16'h8100, 16'h1000, 16'hc600,
      16'h8b00, 16'ha000, 16'hd000, 16'hc900, 16'hc300, 16'h7000, 16'he000};
   localparam logic [15:0] MSK [NK] = '{16'h0000, 16'h0f00, 16'h0f00, 16'h0f00, 16'h0f00,
      16'h0f00, 16'h0f00, 16'h0ff0, 16'h0ff0, 16'h00ff, 16'h00ff, 16'h0fff, 16'h00ff,
      16'h00ff, 16'h0fff, 16'h0fff, 16'h00ff, 16'h00ff, 16'h0fff, 16'h0fff};
   localparam ifd_fmt_t FMT [NK] = '{IFD_FMT_ZERO, IFD_FMT_N, IFD_FMT_N, IFD_FMT_M,
      IFD_FMT_M, IFD_FMT_M, IFD_FMT_M, IFD_FMT_NM, IFD_FMT_NM, IFD_FMT_MD, IFD_FMT_ND4,
      IFD_FMT_NMD, IFD_FMT_D, IFD_FMT_D, IFD_FMT_D12, IFD_FMT_ND8, IFD_FMT_I, IFD_FMT_I,
      IFD_FMT_NI, IFD_FMT_NI};
   localparam int EXT [NK] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 3, 0, 4, 5, 0, 7, 8, 6, 6};
   // {dst_vld, src_vld, r0_dst, r0_src, gbr_base, pc_rel, mac_pair, n_predec, m_postinc}
   localparam logic [8:0] FLG [NK] = '{9'h000, 9'h100, 9'h102, 9'h080, 9'h081, 9'h080, 9'h088,
      9'h180, 9'h085, 9'h1c0, 9'h1a0, 9'h180, 9'h150, 9'h008, 9'h008, 9'h108, 9'h1e0, 9'h000,
      9'h100, 9'h100};

   logic        clk;
   logic        srst;
   logic        stall_en;
   logic [15:0] insn;
   logic        insn_vld;
   ifd_dec_t    dec;
   logic        dec_vld;
   int          n_fail;
   int          n_tests;
   int          cyc;
   int          kq[$];
   logic        pend;
   logic        rst_seen;
   logic [15:0] pend_w;
   int          pend_k;

   ifd_decoder dut (.clk(clk), .srst(srst), .insn(insn), .insn_vld(insn_vld),
                    .dec(dec), .dec_vld(dec_vld));
   ifd_fetch_model fetch (.clk(clk), .stall_en(stall_en), .insn(insn), .insn_vld(insn_vld));

   // ===============================================
   // compare and report
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_fmt(input ifd_fmt_t got, input ifd_fmt_t exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: fmt got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ===============================================
   // reference model
   function automatic logic [31:0] exp_ext(input logic [15:0] w, input int s);
      int v;
      v = (s == 5) ? int'(w[11:0]) : (s >= 4) ? int'(w[7:0]) : int'(w[3:0]);
      if (s == 5 && v > 2047) v -= 4096;
      if ((s == 4 || s == 6) && v > 127) v -= 256;
      case (s)
         2, 4, 5: v = v * 2;
         3, 8:    v = v * 4;
         default: ;
      endcase
      return 32'(v);
   endfunction

   // every operand-use flag at once, so a stray flag is caught as well as a missing one
   function automatic logic [8:0] flags_got();
      return {dec.dst_vld, dec.src_vld, dec.r0_dst, dec.r0_src, dec.gbr_base, dec.pc_rel,
              dec.mac_pair, dec.n_predec, dec.m_postinc};
   endfunction

   task automatic check_word(input logic [15:0] w, input int k);
      chk_fmt(dec.fmt, FMT[k]);
      case (FMT[k])
         IFD_FMT_ZERO: chk_val(32'({dec.dst_vld, dec.src_vld}), 32'h0);
         IFD_FMT_N:    chk_val(32'({dec.dst_vld, dec.dst_idx}), {27'h0, 1'b1, w[11:8]});
         IFD_FMT_M:    chk_val(32'({dec.src_vld, dec.src_idx}), {27'h0, 1'b1, w[11:8]});
         IFD_FMT_NM:   chk_val(32'({dec.dst_idx, dec.src_idx}), 32'(w[11:4]));
         IFD_FMT_MD:   chk_val(32'({dec.src_idx, dec.disp_raw}), {16'h0, w[7:4], 8'h0, w[3:0]});
         IFD_FMT_ND4:  chk_val(32'({dec.dst_idx, dec.disp_raw}), {16'h0, w[7:4], 8'h0, w[3:0]});
         IFD_FMT_NMD:  chk_val(32'({dec.dst_idx, dec.src_idx, dec.disp_raw}),
                               {12'h0, w[11:4], 8'h0, w[3:0]});
         IFD_FMT_D:    chk_val(32'(dec.disp_raw[7:0]), 32'(w[7:0]));
         IFD_FMT_D12:  chk_val(32'(dec.disp_raw), 32'(w[11:0]));
         IFD_FMT_ND8:  chk_val(32'({dec.dst_idx, dec.disp_raw[7:0]}), 32'(w[11:0]));
         IFD_FMT_I:    chk_val(32'(dec.imm_raw), 32'(w[7:0]));
         default:      chk_val(32'({dec.dst_idx, dec.imm_raw}), 32'(w[11:0]));
      endcase
      if (EXT[k] inside {[1:3]}) chk_val(dec.operand_ext, exp_ext(w, EXT[k]));
      if (EXT[k] inside {[4:5]}) chk_val(dec.operand_ext, exp_ext(w, EXT[k]));
      if (EXT[k] >= 6) chk_val(dec.operand_ext, exp_ext(w, EXT[k]));
      chk_val(32'(flags_got()), 32'(FLG[k]));
   endtask

   // ===============================================
   // clock, acceptance tracking and result checking
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // note what was taken at each edge, reset included
   always @(posedge clk) begin
      rst_seen <= srst;
      pend     <= insn_vld && !srst;
      pend_w   <= insn;
      if (insn_vld) pend_k <= kq.pop_front();
   end

   // results are settled by the falling edge
   always @(negedge clk) begin
      if (rst_seen) begin
         chk_val(32'({dec_vld, |dec}), 32'h0);
      end else begin
         chk_val(32'(dec_vld), 32'(pend));
         if (pend) check_word(pend_w, pend_k);
      end
   end

   // hang guard
   always @(negedge clk) begin
      cyc++;
      if (cyc >= CYC_MAX) begin
         n_fail++;
         $display("Error at %0t: cycle limit %h reached", $time, cyc);
         summarize();
      end
   end

   // ===============================================
   // stimulus
   task automatic send(input logic [15:0] w, input int k);
      kq.push_back(k);
      fetch.push(w);
   endtask

   task automatic drain(input string name);
      for (int i = 0; i < 2000 && fetch.depth() != 0; i++) @(negedge clk);
      repeat (3) @(negedge clk);
      $display("test %s done", name);
   endtask

   initial begin
      int k;
      srst     = 1'b1;
      stall_en = 1'b0;
      n_fail   = 0;
      n_tests  = 0;
      cyc      = 0;
      pend     = 1'b0;
      rst_seen = 1'b1;
      void'($urandom(48));
      repeat (12) @(negedge clk);
      srst = 1'b0;
      send(16'h7a05, 18);
      drain("walk");
      // every format back to back, jump and pc-offset sources included
      for (int r = 0; r < 6; r++)
         for (int j = 0; j < NK; j++) send(TMPL[j] | (16'($urandom) & MSK[j]), j);
      drain("formats");
      // field extremes with the fetch side stalling
      stall_en = 1'b1;
      for (int j = 0; j < NK; j++) begin
         send(TMPL[j], j);
         send(TMPL[j] | MSK[j], j);
      end
      drain("extremes");
      // reset lands in mid-stream
      stall_en = 1'b0;
      for (int j = 0; j < 12; j++) begin
         k = $urandom_range(NK - 1);
         send(TMPL[k] | (16'($urandom) & MSK[k]), k);
      end
      repeat (4) @(negedge clk);
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      drain("reset");
      summarize();
   end
endmodule // test_instr_format_field_decoder
